// [src/sbd_pkg.sv]
package sbd_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // Register indices as printed, byte address is four times the index
  localparam logic [15:0] SBD_MASK_IDX      = 16'h1C20;
  localparam logic [15:0] SBD_PEND_IDX      = 16'h1C21;
  localparam logic [17:0] SBD_MASK_ADDR     = {SBD_MASK_IDX, 2'b00};
  localparam logic [17:0] SBD_PEND_ADDR     = {SBD_PEND_IDX, 2'b00};
  localparam int          SBD_ADDR_W        = 18;

  // Mask register fields
  localparam int          SBD_MASK_BIT      = 0;
  localparam logic        SBD_MASK_RST      = 1'b1;

  // Pending register fields
  localparam int          SBD_B_RSN_LSB     = 10;
  localparam int          SBD_B_PORT_LSB    = 8;
  localparam int          SBD_B_PEND_BIT    = 7;
  localparam int          SBD_A_RSN_LSB     = 3;
  localparam int          SBD_A_PORT_LSB    = 1;
  localparam int          SBD_A_VAL_BIT     = 0;
  localparam logic [3:0]  SBD_RSN_RST       = 4'h0;
  localparam logic [1:0]  SBD_PORT_RST      = 2'h0;

  // ----------------------------------------------------------------
  // Drop reason codes
  // ----------------------------------------------------------------
  localparam logic [3:0]  SBD_RSN_BCAST_LIM = 4'h0;
  localparam logic [3:0]  SBD_RSN_RED       = 4'h1;
  localparam logic [3:0]  SBD_RSN_NO_BUF    = 4'h2;
  localparam logic [3:0]  SBD_RSN_NO_DESC   = 4'h3;
  localparam logic [3:0]  SBD_RSN_NO_DEST   = 4'h4;
  localparam logic [3:0]  SBD_RSN_RX_ERR    = 4'h5;
  localparam logic [3:0]  SBD_RSN_BUF_LIM   = 4'h6;
  localparam logic [3:0]  SBD_RSN_YELLOW    = 4'h9;

  // Drop cause vector positions, lowest index wins
  localparam int          SBD_CAUSE_N       = 8;
  localparam int          SBD_C_BCAST_LIM   = 0;
  localparam int          SBD_C_RED         = 1;
  localparam int          SBD_C_NO_BUF      = 2;
  localparam int          SBD_C_NO_DESC     = 3;
  localparam int          SBD_C_NO_DEST     = 4;
  localparam int          SBD_C_RX_ERR      = 5;
  localparam int          SBD_C_BUF_LIM     = 6;
  localparam int          SBD_C_YELLOW      = 7;

  // Receive errors count only on frames longer than this
  localparam logic [11:0] SBD_RX_ERR_MIN    = 12'h040;
  localparam int          SBD_LEN_W         = 12;

  // Largest legal port code
  localparam logic [1:0]  SBD_PORT_MAX      = 2'h2;

endpackage

// [src/sbd_drop_capture.sv]
// Implementation choice: the APB register port.
`timescale 1ns/1ns
// Overview of operation
// - Mask bit 0 set suppresses the interrupt; clearing it lets pending events through.
// - Mask bit resets to one, interrupts masked until software clears it.
// - Mask changes never touch captured status; capture continues while masked.
// - Two capture sets, A and B, hold two drop events: A the first, B the next while A is valid.
// - Code 0000: unknown/broadcast frame dropped over broadcast buffer limit.
// - Code 0001: red frame dropped while red discarding enabled.
// - Code 0010: frame dropped, no packet buffers free.
// - Code 0011: frame dropped, no memory descriptors free.
// - Code 0100: unknown/broadcast frame dropped, no valid destination port.
// - Code 0101: frame over 64 bytes with receive error dropped.
// - Code 0110: frame dropped over general buffer drop limit.
// - Code 1001: yellow discarding enabled and yellow frame randomly chosen.
// - Set B reason in bits 13:10 meaningful only while B pending.
// - Set B source port in bits 9:8 while B pending.
// - Bit 7 is set B pending flag validating bits 13:8.
// - Set A reason in bits 6:3 uses the same encoding.
// - Set A port in bits 2:1: 00,01,10 ports 0-2, 11 unused.
// - Bit 0 is set A valid flag validating bits 6:1.
module sbd_drop_capture
  import sbd_pkg::*;
#(
  parameter int ADDR_W = SBD_ADDR_W
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [ADDR_W-1:0]      paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   drop_valid,
  input  wire logic [SBD_CAUSE_N-1:0] drop_cause,
  input  wire logic [1:0]             drop_port,
  input  wire logic [SBD_LEN_W-1:0]   drop_len,
  output logic                        drop_irq
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (ADDR_W < SBD_ADDR_W) begin : g_addr_chk
    $error("ADDR_W too narrow for the register map");
  end

  // Encoder below serves exactly eight causes
  if (SBD_CAUSE_N != 8) begin : g_cause_chk
    $error("Drop cause vector must be eight wide");
  end

  // Length must tell a frame past the short-frame limit
  if (SBD_LEN_W < 7) begin : g_len_chk
    $error("Frame length too narrow for the receive error limit");
  end

  // Set B fields must sit above set A fields
  if (SBD_B_PEND_BIT <= SBD_A_RSN_LSB + 3) begin : g_field_chk
    $error("Capture set fields overlap");
  end

  // Set B reason must fit inside the data word
  if (SBD_B_RSN_LSB + 4 > 32) begin : g_word_chk
    $error("Pending register fields exceed the data word");
  end

  // Two registers need two addresses
  if (SBD_MASK_ADDR == SBD_PEND_ADDR) begin : g_map_chk
    $error("Mask and pending registers share an address");
  end

  // Mask bit must sit in the byte lane of pstrb[0]
  if (SBD_MASK_BIT > 7) begin : g_lane_chk
    $error("Mask bit outside the low byte lane");
  end

  // Unused port code must stay out of the legal range
  if (SBD_PORT_MAX == 2'h3) begin : g_port_chk
    $error("Largest port code must leave the unused code free");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  // Mask and interrupt state
  logic                   mask_q;
  logic                   mask_d;
  logic                   irq_q;
  logic                   irq_d;

  // Capture set A
  logic                   a_val_q;
  logic                   a_val_d;
  logic [3:0]             a_rsn_q;
  logic [3:0]             a_rsn_d;
  logic [1:0]             a_port_q;
  logic [1:0]             a_port_d;

  // Capture set B
  logic                   b_pend_q;
  logic                   b_pend_d;
  logic [3:0]             b_rsn_q;
  logic [3:0]             b_rsn_d;
  logic [1:0]             b_port_q;
  logic [1:0]             b_port_d;

  // Bus answer
  logic [31:0]            prdata_q;
  logic [31:0]            prdata_d;
  logic                   pready_q;
  logic                   pready_d;
  logic                   pslverr_q;
  logic                   pslverr_d;

  // Bus decode
  logic                   setup;
  logic                   access;
  logic                   wr_done;
  logic                   hit_mask;
  logic                   hit_pend;
  logic                   mapped;
  logic                   rd_clr;

  // Event path
  logic                   long_frame;
  logic [SBD_CAUSE_N-1:0] cause_hit;
  logic                   ev_ok;
  logic [3:0]             ev_rsn;

  // Register images
  logic [31:0]            pend_word;
  logic [31:0]            mask_word;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Setup phase, access phase and completed access phase
  assign setup    = psel & ~penable;
  assign access   = psel & penable;
  assign wr_done  = access & pready_q & pwrite;

  // Address match, anything else answers with an error
  assign hit_mask = (paddr == ADDR_W'(SBD_MASK_ADDR));
  assign hit_pend = (paddr == ADDR_W'(SBD_PEND_ADDR));
  assign mapped   = hit_mask | hit_pend;
  assign rd_clr   = setup & ~pwrite & hit_pend;

  // Pending register image, reserved bits zero
  always_comb begin
    pend_word = 32'h0000_0000;
    pend_word[SBD_B_RSN_LSB +: 4]  = b_rsn_q;
    pend_word[SBD_B_PORT_LSB +: 2] = b_port_q;
    pend_word[SBD_B_PEND_BIT]      = b_pend_q;
    pend_word[SBD_A_RSN_LSB +: 4]  = a_rsn_q;
    pend_word[SBD_A_PORT_LSB +: 2] = a_port_q;
    pend_word[SBD_A_VAL_BIT]       = a_val_q;
  end

  // Mask register image, reserved bits zero
  always_comb begin
    mask_word               = 32'h0000_0000;
    mask_word[SBD_MASK_BIT] = mask_q;
  end

  // ----------------------------------------------------------------
  // Cause qualification
  // ----------------------------------------------------------------
  // only long frames count as receive errors
  assign long_frame = (drop_len > SBD_RX_ERR_MIN);

  // One qualified flag per cause, a short errored frame is no cause
  for (genvar gi = 0; gi < SBD_CAUSE_N; gi++) begin : g_cause
    if (gi == SBD_C_RX_ERR) begin : g_rx
      assign cause_hit[gi] = drop_cause[gi] & long_frame;
    end else begin : g_plain
      assign cause_hit[gi] = drop_cause[gi];
    end
  end

  // ----------------------------------------------------------------
  // Drop reason encoder
  // ----------------------------------------------------------------
  // Lowest cause index wins when several are raised together
  always_comb begin
    ev_rsn = SBD_RSN_BCAST_LIM;
    ev_ok  = 1'b1;
    if (cause_hit[SBD_C_BCAST_LIM]) begin
      ev_rsn = SBD_RSN_BCAST_LIM;
    end else if (cause_hit[SBD_C_RED]) begin
      ev_rsn = SBD_RSN_RED;
    end else if (cause_hit[SBD_C_NO_BUF]) begin
      ev_rsn = SBD_RSN_NO_BUF;
    end else if (cause_hit[SBD_C_NO_DESC]) begin
      ev_rsn = SBD_RSN_NO_DESC;
    end else if (cause_hit[SBD_C_NO_DEST]) begin
      ev_rsn = SBD_RSN_NO_DEST;
    end else if (cause_hit[SBD_C_RX_ERR]) begin
      ev_rsn = SBD_RSN_RX_ERR;
    end else if (cause_hit[SBD_C_BUF_LIM]) begin
      ev_rsn = SBD_RSN_BUF_LIM;
    end else if (cause_hit[SBD_C_YELLOW]) begin
      ev_rsn = SBD_RSN_YELLOW;
    end else begin
      ev_ok  = 1'b0;
    end
    if (!drop_valid || (drop_port > SBD_PORT_MAX)) begin
      ev_ok = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Capture sets
  // ----------------------------------------------------------------
  // Clear from a read comes first, so a same-cycle event is kept
  always_comb begin
    a_val_d  = a_val_q;
    a_rsn_d  = a_rsn_q;
    a_port_d = a_port_q;
    b_pend_d = b_pend_q;
    b_rsn_d  = b_rsn_q;
    b_port_d = b_port_q;
    if (rd_clr) begin
      a_val_d  = 1'b0;
      a_rsn_d  = SBD_RSN_RST;
      a_port_d = SBD_PORT_RST;
      b_pend_d = 1'b0;
      b_rsn_d  = SBD_RSN_RST;
      b_port_d = SBD_PORT_RST;
    end
    if (ev_ok) begin
      if (!a_val_d) begin
        a_val_d  = 1'b1;
        a_rsn_d  = ev_rsn;
        a_port_d = drop_port;
      end else if (!b_pend_d) begin
        b_pend_d = 1'b1;
        b_rsn_d  = ev_rsn;
        b_port_d = drop_port;
      end
    end
  end

  // Capture set registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_val_q  <= 1'b0;
      a_rsn_q  <= SBD_RSN_RST;
      a_port_q <= SBD_PORT_RST;
      b_pend_q <= 1'b0;
      b_rsn_q  <= SBD_RSN_RST;
      b_port_q <= SBD_PORT_RST;
    end else begin
      a_val_q  <= a_val_d;
      a_rsn_q  <= a_rsn_d;
      a_port_q <= a_port_d;
      b_pend_q <= b_pend_d;
      b_rsn_q  <= b_rsn_d;
      b_port_q <= b_port_d;
    end
  end

  // ----------------------------------------------------------------
  // Mask register and interrupt
  // ----------------------------------------------------------------
  // Mask write touches only the mask, never the capture sets
  always_comb begin
    mask_d = mask_q;
    if (wr_done && hit_mask && pstrb[0]) begin
      mask_d = pwdata[SBD_MASK_BIT];
    end
  end

  // Mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= SBD_MASK_RST;
    end else begin
      mask_q <= mask_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  // Built from next values, so it moves at the capture or mask edge
  always_comb begin
    irq_d = (a_val_d | b_pend_d) & ~mask_d;
  end

  // Interrupt register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  // Read data snapshot taken in setup, held until the next setup
  always_comb begin
    prdata_d = prdata_q;
    if (setup) begin
      prdata_d = 32'h0000_0000;
      if (!pwrite && hit_mask) begin
        prdata_d = mask_word;
      end else if (!pwrite && hit_pend) begin
        prdata_d = pend_word;
      end
    end
  end

  // Read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  // Ready in the first access cycle, error only on unmapped addresses
  always_comb begin
    pready_d  = setup;
    pslverr_d = setup & ~mapped;
  end

  // Handshake registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Outputs straight from flip-flops
  assign prdata   = prdata_q;
  assign pready   = pready_q;
  assign pslverr  = pslverr_q;
  assign drop_irq = irq_q;

endmodule

// [verification/sbd_drop_capture_asserts.sv]
`timescale 1ns/1ns
module sbd_drop_capture_chk
  import sbd_pkg::*;
#(
  parameter int ADDR_W = SBD_ADDR_W
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              drop_valid,
  input wire logic [7:0]        drop_cause,
  input wire logic [1:0]        drop_port,
  input wire logic [11:0]       drop_len,
  input wire logic              drop_irq
);
  // ---------------------------------------------
  // Bus phase decode
  // ---------------------------------------------
  logic pnd;
  logic rd;
  logic wm;
  logic dp;
  assign pnd = paddr == ADDR_W'(SBD_PEND_ADDR);
  assign rd  = psel && !penable && !pwrite && pnd;
  assign wm  = psel && penable && pready && pwrite && pstrb[0] && paddr == ADDR_W'(SBD_MASK_ADDR);
  assign dp  = psel && penable && pready && !pwrite && pnd;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Checks on interrupt and read data
  a_rd_clear: assert property (rd && !drop_valid |=> !drop_irq)
    else $error("irq kept after pending read");
  a_mask_irq_off: assert property (wm && pwdata[0] |=> !drop_irq)
    else $error("irq kept after mask set");
  a_irq_rise: assert property ($rose(drop_irq) |-> $past(drop_valid) || $past(wm))
    else $error("irq rose without cause");
  a_irq_fall: assert property ($fell(drop_irq) |-> $past(rd) || $past(wm))
    else $error("irq fell without cause");
  a_port_legal: assert property (dp |-> prdata[2:1] != 2'h3 && prdata[9:8] != 2'h3)
    else $error("unused port code read");
  a_rsn_legal: assert property (dp && prdata[0] |-> prdata[6:3] inside {[4'h0:4'h6], 4'h9})
    else $error("undefined reason code read");
  a_rsn_b_legal: assert property (dp && prdata[7] |-> prdata[13:10] inside {[4'h0:4'h6], 4'h9})
    else $error("undefined set B reason code read");
  a_b_needs_a: assert property (dp && prdata[7] |-> prdata[0])
    else $error("set B filled before set A");
  a_a_empty_zero: assert property (dp && !prdata[0] |-> prdata[6:1] == 6'h00)
    else $error("set A fields without valid");
  a_b_empty_zero: assert property (dp && !prdata[7] |-> prdata[13:8] == 6'h00)
    else $error("set B fields without pending");
endmodule

bind sbd_drop_capture sbd_drop_capture_chk #(.ADDR_W(ADDR_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .drop_valid(drop_valid), .drop_cause(drop_cause),
  .drop_port(drop_port), .drop_len(drop_len), .drop_irq(drop_irq)
);

// [verification/sbd_drop_capture_tb.sv]
`timescale 1ns/1ns
`define CHK(n, x, g) begin compares++; if ((g) !== (x)) begin num_errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, x, g); end end
module switch_buffer_drop_event_capture_tb;
  import sbd_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [17:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r, rnd;
  logic [3:0]  pstrb = 0;
  logic        pready, pslverr, e, drop_irq, drop_valid = 0, m_mask = 1;
  logic [7:0]  drop_cause = 0;
  logic [1:0]  drop_port = 0;
  logic [11:0] drop_len = 0;
  logic [6:0]  sa = 0, sb = 0;
  int          num_errors = 0, compares = 0, seed = 47614, n_ev = 0;
  // ---------------------------------------------
  // Clock, design and watchdog
  // ---------------------------------------------
  always #2 pclk = ~pclk;
  sbd_drop_capture uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .drop_valid(drop_valid), .drop_cause(drop_cause),
    .drop_port(drop_port), .drop_len(drop_len), .drop_irq(drop_irq));
  initial begin
    #80000;
    num_errors++;
    wrap_up;
  end
  // Reason code of the winning cause, top bit marks a usable event
  function automatic logic [4:0] rsn_of(logic [7:0] c, logic [11:0] l);
    logic [3:0] t [8];
    t = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9};
    for (int i = 0; i < 8; i++) begin
      if (c[i] && !(i == 5 && l <= 12'h040)) return {1'b1, t[i]};
    end
    return 5'h00;
  endfunction
  // One APB transfer, held until pready
  task apb(input logic w, input logic [17:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer, only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd_pend;
    apb(1'b0, SBD_PEND_ADDR, 32'h0, 4'hF);
    `CHK("pending", {18'h0, sb, sa}, r)
    sa = 0;
    sb = 0;
  endtask
  task wr_mask(input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, SBD_MASK_ADDR, d, s);
    if (s[0]) m_mask = d[0];
    `CHK("mask err", 1'b0, e)
  endtask
  // Drop event strobe, model fills A then B then discards
  task ev(input logic [7:0] c, input logic [1:0] p, input logic [11:0] l);
    logic [4:0] t;
    drop_valid <= 1'b1;
    drop_cause <= c;
    drop_port <= p;
    drop_len <= l;
    @(posedge pclk);
    t = rsn_of(c, l);
    if (t[4] && p != 2'h3 && !sa[0]) sa = {t[3:0], p, 1'b1};
    else if (t[4] && p != 2'h3 && !sb[0]) sb = {t[3:0], p, 1'b1};
  endtask
  task idle;
    drop_valid <= 1'b0;
    @(posedge pclk);
    `CHK("irq", (sa[0] | sb[0]) & ~m_mask, drop_irq)
  endtask
  task end_test(input string s);
    $display("test %s done", s);
  endtask
  task wrap_up;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ---------------------------------------------
  // Test sequence
  // ---------------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, SBD_MASK_ADDR, 32'h0, 4'hF);
    `CHK("mask reset", 32'h1, r)
    rd_pend;
    end_test("reset");
    for (int i = 0; i < 8; i++) begin
      ev(8'h01 << i, 2'(i % 3), 12'h080);
      ev(8'h01 << ((i + 3) % 8), 2'((i + 1) % 3), 12'h041);
      ev(8'h04, 2'h2, 12'h100);
      idle;
      if (i == 2) begin
        wr_mask(32'h0, 4'hF);
        idle;
        wr_mask(32'h1, 4'hE);
        idle;
        wr_mask(32'h1, 4'hF);
        idle;
      end
      rd_pend;
      rd_pend;
    end
    end_test("codes and sets");
    ev(8'h00, 2'h1, 12'h080);
    ev(8'h20, 2'h0, 12'h040);
    ev(8'h04, 2'h3, 12'h080);
    ev(8'h20, 2'h2, 12'h041);
    idle;
    apb(1'b1, SBD_PEND_ADDR, 32'h0, 4'hF);
    apb(1'b1, SBD_MASK_ADDR + 18'h8, 32'h0, 4'hF);
    `CHK("unmapped wr err", 1'b1, e)
    idle;
    rd_pend;
    apb(1'b0, SBD_PEND_ADDR + 18'h4, 32'h0, 4'hF);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, r)
    // Event at the very edge that takes a pending read
    fork
      apb(1'b0, SBD_PEND_ADDR, 32'h0, 4'hF);
      begin
        @(posedge pclk);
        drop_valid <= 1'b1;
        drop_cause <= 8'h02;
        drop_port <= 2'h1;
        @(posedge pclk);
        drop_valid <= 1'b0;
      end
    join
    `CHK("read with event", 32'h0, r)
    sa = {SBD_RSN_RED, 2'h1, 1'b1};
    rd_pend;
    end_test("refusals");
    // Reset in mid-run with an event captured and the mask open
    ev(8'h08, 2'h0, 12'h080);
    idle;
    wr_mask(32'h0, 4'hF);
    idle;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    sa = 0;
    m_mask = 1'b1;
    idle;
    apb(1'b0, SBD_MASK_ADDR, 32'h0, 4'hF);
    `CHK("mask after reset", 32'h1, r)
    rd_pend;
    end_test("mid-run reset");
    repeat (150) begin
      rnd = $random(seed);
      n_ev = rnd[9:8];
      for (int k = 0; k < n_ev; k++) begin
        rnd = $random(seed);
        ev(rnd[7:0], rnd[9:8], 12'h041 + 12'(rnd[18:10]));
      end
      idle;
      rnd = $random(seed);
      if (rnd[1:0] == 2'h0) wr_mask({31'h0, rnd[2]}, 4'hF);
      idle;
      rd_pend;
    end
    end_test("random");
    wrap_up;
  end
endmodule
